/* File: src/asc_pkg.sv */
/*
  Shared constants and types of the serial command port.
  Assumes one device clock domain; pins are resynchronised locally.
*/
// ==========================================================
// Serial command port package
package asc_pkg;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned CODE_HI = 7;
  localparam int unsigned CODE_LO = 4;
  localparam int unsigned INTEG_W = 16;
  localparam int unsigned FRAC_W = 5;
  localparam int unsigned CNT_W = 21;
  localparam int unsigned RES_W = 24;
  localparam int unsigned CFG_N = 5;
  localparam int unsigned AUX_W = 4;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] BITS_SAT = 4'hf;
  localparam logic [2:0] ZERO_RUN = 3'h4;
  // Pin vector positions inside the resynchroniser
  localparam int unsigned PIN_CS = 2;
  localparam int unsigned PIN_SK = 1;
  localparam int unsigned PIN_SI = 0;
  // Status byte layout
  localparam int unsigned STAT_DONE = 7;
  localparam int unsigned STAT_AUX_LO = 0;
  // Setup byte fields
  localparam int unsigned ATTEN_LO = 0;
  localparam int unsigned AUXO_LO = 4;
  localparam int unsigned MUX_LO = 0;
  localparam int unsigned GAIN_LO = 3;
  localparam int unsigned CJC_BIT = 6;
  // Read register indexes
  localparam logic [2:0] IDX_STATUS = 3'h0;
  localparam logic [2:0] IDX_RES_FIRST = 3'h1;
  localparam logic [2:0] IDX_RES_SECOND = 3'h2;
  localparam logic [2:0] IDX_RES_THIRD = 3'h3;
  // Write register indexes
  localparam logic [2:0] IDX_CNT_LOW = 3'h0;
  localparam logic [2:0] IDX_CNT_HIGH = 3'h1;
  localparam logic [2:0] IDX_ATTEN = 3'h2;
  localparam logic [2:0] IDX_MUX = 3'h3;
  localparam logic [2:0] IDX_EXC = 3'h4;

  typedef enum logic [3:0] {
    CMD_NOP = 4'h0, CMD_RD_STATUS = 4'h1, CMD_RD_FIRST = 4'h2,
    CMD_RD_SECOND = 4'h3, CMD_RD_THIRD = 4'h4, CMD_RD_ALL = 4'h5,
    CMD_WR_LOW = 4'h8, CMD_WR_HIGH = 4'h9, CMD_WR_COUNT = 4'ha,
    CMD_WR_ATTEN = 4'hb, CMD_WR_MUX = 4'hc, CMD_WR_EXC = 4'hd,
    CMD_WR_SETUP = 4'he, CMD_START = 4'hf
  } asc_cmd_t;

  typedef enum logic [2:0] {
    ST_CMD = 3'b001,
    ST_READ = 3'b010,
    ST_WRITE = 3'b100
  } asc_state_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [2:0] idx;
    logic [1:0] cnt;
  } asc_plan_t;
endpackage : asc_pkg

/* File: src/asc_byte_if.sv */
/*
  Byte hand-off between the pin shifter and the command core.
  Assumes both ends run on the device clock.
*/
// ==========================================================
// Byte carrier
interface asc_byte_if;
  logic rx_valid;
  logic [7:0] rx_byte;
  logic [7:0] tx_byte;
  logic tx_en;
  modport port (output rx_valid, rx_byte, input tx_byte, tx_en);
  modport core (input rx_valid, rx_byte, output tx_byte, tx_en);
endinterface : asc_byte_if

/* File: src/asc_shifter.sv */
/*
  Pin-level byte shifter: resynchronises select, shift clock and
  data in, shifts bytes in and out. Assumes shift clock far slower
  than the device clock (several device cycles per level).
*/
module asc_shifter
  import asc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic cs_b_i,
  input wire logic sk_i,
  input wire logic si_i,
  asc_byte_if.port bus,
  output logic so_o,
  output logic so_oe_o
);
  typedef struct packed {
    logic [2:0] s0;
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] q;
    logic [3:0] bits;
    logic [7:0] rxsh;
    logic [7:0] txsh;
    logic so;
    logic oe;
    logic rx_valid;
    logic [7:0] rx_byte;
  } asc_shift_t;

  asc_shift_t r;
  asc_shift_t n;
  logic [2:0] agree;
  logic [2:0] q_nxt;

  // A pin level counts once the second and third stages agree
  assign agree = ~(r.s1 ^ r.s2);
  assign q_nxt = (r.s2 & agree) | (r.q & ~agree);

  always_comb begin
    n = r;
    n.s0 = {cs_b_i, sk_i, si_i};
    n.s1 = r.s0;
    n.s2 = r.s1;
    n.q = q_nxt;
    n.rx_valid = 1'b0;
    // R03 byte framed by select
    if (r.q[PIN_CS] && !q_nxt[PIN_CS]) begin
      n.bits = 4'h0;
      n.txsh = bus.tx_byte;
      n.so = bus.tx_byte[BYTE_W-1];
      // R01 drive only for reads
      n.oe = bus.tx_en;
    end else if (!r.q[PIN_CS] && q_nxt[PIN_CS]) begin
      n.oe = 1'b0;
      // Short or long frames are dropped whole
      if (r.bits == BITS_PER_BYTE) begin
        n.rx_valid = 1'b1;
        n.rx_byte = r.rxsh;
      end
    end else if (!r.q[PIN_CS]) begin
      // R04 sample on rising edge
      if (!r.q[PIN_SK] && q_nxt[PIN_SK]) begin
        // R26 most significant first
        n.rxsh = {r.rxsh[6:0], r.q[PIN_SI]};
        if (r.bits != BITS_SAT) begin
          n.bits = r.bits + 4'h1;
        end
      end
      // R04 next bit after falling edge
      if (r.q[PIN_SK] && !q_nxt[PIN_SK]) begin
        n.txsh = {r.txsh[6:0], 1'b0};
        n.so = r.txsh[6];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      r <= '{s0: 3'h7, s1: 3'h7, s2: 3'h7, q: 3'h7, default: '0};
    end else begin
      r <= n;
    end
  end

  assign bus.rx_valid = r.rx_valid;
  assign bus.rx_byte = r.rx_byte;
  assign so_o = r.so;
  assign so_oe_o = r.oe;
endmodule : asc_shifter

/* File: src/asc_integrator.sv */
/*
  Integration timer and result accumulator of the converter.
  Assumes a one-bit charge-balance decision each device clock.
*/
module asc_integrator
  import asc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic start_i,
  input wire logic abort_i,
  input wire logic [INTEG_W-1:0] integ_i,
  input wire logic mod_bit_i,
  output logic busy_o,
  output logic done_o,
  output logic [RES_W-1:0] result_o
);
  typedef struct packed {
    logic busy;
    logic done;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] ones;
    logic [RES_W-1:0] res;
  } asc_integ_t;

  asc_integ_t r;
  asc_integ_t n;
  logic [CNT_W-1:0] period;
  logic [CNT_W-1:0] cnt_nxt;
  logic [CNT_W-1:0] ones_nxt;

  // R21 value is top of 21-bit count
  assign period = {integ_i, {FRAC_W{1'b0}}};
  assign cnt_nxt = r.cnt + CNT_W'(1);
  assign ones_nxt = r.ones + CNT_W'(mod_bit_i);

  always_comb begin
    n = r;
    n.done = 1'b0;
    if (start_i) begin
      n.busy = 1'b1;
      n.cnt = '0;
      n.ones = '0;
    end else if (r.busy) begin
      if (abort_i) begin
        n.busy = 1'b0;
      end else begin
        n.cnt = cnt_nxt;
        n.ones = ones_nxt;
        // A zero count ends after a single cycle
        if (cnt_nxt >= period) begin
          n.busy = 1'b0;
          n.done = 1'b1;
          // R22 full scale is half the cycles
          n.res = RES_W'(ones_nxt) - RES_W'(period >> 1);
        end
      end
    end
  end

  // R24 reset ends any conversion
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign busy_o = r.busy;
  assign done_o = r.done;
  assign result_o = r.res;
endmodule : asc_integrator

/* File: src/asc_serial_port.sv */
/*
  Serial command port of the integrating converter: command
  sequencer, setup bytes, status and result bytes, conversion
  control. Assumes the host is a byte-framing serial master and
  that the analog side supplies one decision bit per clock.
*/
// ==========================================================
// Operation
// R01 - Output floats except while returning read bytes
// R02 - Done pin copies status done bit
// R03 - Each byte framed by select low then high
// R04 - Sample on shift rise, host takes on fall
// R05 - Host keeps shift clock high at select edges
// R06 - First byte loads four-bit command code
// R07 - Reset leaves port expecting a command
// R08 - Unknown and spare codes do nothing
// R09 - Read codes: status, three results, all results
// R10 - Write codes: count, setup bytes, start
// R11 - Reset or four zero bytes restore command mode
// R12 - Two low setup bytes form integration count
// R13 - Third byte: attenuators and auxiliary outputs
// R14 - Fourth: mux, gain, junction bit; fifth: excitation
// R15 - Setup bytes hold values, undefined at power-up
// R16 - Setup write aborts running conversion, still latches
// R17 - Results are 24-bit signed; status holds inputs, done
// R18 - Results keep last completed conversion
// R19 - Host moves single byte right after command
// R20 - Multi-byte moves ascending, each byte framed
// R21 - Count is upper 16 of 21-bit timer
// R22 - Full scale is half the integration cycles
// R23 - Done low while converting, high when fresh
// R24 - Reset ends conversion and clears its control
// R25 - Reset leaves setup bytes untouched
// R26 - Bits travel most significant first
module asc_serial_port
  import asc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic cs_b_i,
  input wire logic shift_clock_i,
  input wire logic serial_in_i,
  output logic serial_out_o,
  output logic serial_out_oe_o,
  output logic conversion_done_o,
  output logic converting_o,
  input wire logic mod_bit_i,
  input wire logic [AUX_W-1:0] aux_in_i,
  output logic [AUX_W-1:0] aux_out_o,
  output logic [AUX_W-1:0] atten_en_o,
  output logic [2:0] mux_sel_o,
  output logic [2:0] gain_sel_o,
  output logic cjc_exc_o,
  output logic [7:0] exc_ctrl_o
);
  // ========================================================
  // State
  typedef struct packed {
    asc_state_t st;
    logic [2:0] idx;
    logic [1:0] left;
    logic [2:0] zeros;
    logic [7:0] tx_byte;
    logic tx_en;
    logic done;
    logic start;
    logic abort;
    logic [AUX_W-1:0] aux_s0;
    logic [AUX_W-1:0] aux_s1;
    logic [AUX_W-1:0] aux_s2;
    logic [AUX_W-1:0] aux_q;
  } asc_core_t;

  typedef logic [CFG_N-1:0][7:0] asc_cfg_t;

  asc_core_t r;
  asc_core_t n;
  asc_cfg_t cfg_r;
  asc_cfg_t cfg_nxt;
  asc_plan_t plan;
  asc_byte_if bus ();
  logic conv_busy;
  logic conv_done;
  logic [RES_W-1:0] result;
  logic [AUX_W-1:0] aux_agree;

  // ========================================================
  // Command decode
  // R09 read code table
  // R10 write code table
  function automatic asc_plan_t cmd_plan(input logic [3:0] code);
    asc_plan_t p;
    p = '0;
    case (asc_cmd_t'(code))
      CMD_RD_STATUS: begin
        p = '{rd: 1'b1, wr: 1'b0, idx: IDX_STATUS, cnt: 2'h1};
      end
      CMD_RD_FIRST: begin
        p = '{rd: 1'b1, wr: 1'b0, idx: IDX_RES_FIRST, cnt: 2'h1};
      end
      CMD_RD_SECOND: begin
        p = '{rd: 1'b1, wr: 1'b0, idx: IDX_RES_SECOND, cnt: 2'h1};
      end
      CMD_RD_THIRD: begin
        p = '{rd: 1'b1, wr: 1'b0, idx: IDX_RES_THIRD, cnt: 2'h1};
      end
      CMD_RD_ALL: begin
        p = '{rd: 1'b1, wr: 1'b0, idx: IDX_RES_FIRST, cnt: 2'h3};
      end
      CMD_WR_LOW: begin
        p = '{rd: 1'b0, wr: 1'b1, idx: IDX_CNT_LOW, cnt: 2'h1};
      end
      CMD_WR_HIGH: begin
        p = '{rd: 1'b0, wr: 1'b1, idx: IDX_CNT_HIGH, cnt: 2'h1};
      end
      CMD_WR_COUNT: begin
        p = '{rd: 1'b0, wr: 1'b1, idx: IDX_CNT_LOW, cnt: 2'h2};
      end
      CMD_WR_ATTEN: begin
        p = '{rd: 1'b0, wr: 1'b1, idx: IDX_ATTEN, cnt: 2'h1};
      end
      CMD_WR_MUX: begin
        p = '{rd: 1'b0, wr: 1'b1, idx: IDX_MUX, cnt: 2'h1};
      end
      CMD_WR_EXC: begin
        p = '{rd: 1'b0, wr: 1'b1, idx: IDX_EXC, cnt: 2'h1};
      end
      CMD_WR_SETUP: begin
        p = '{rd: 1'b0, wr: 1'b1, idx: IDX_ATTEN, cnt: 2'h3};
      end
      default: begin
        p = '0;
      end
    endcase
    return p;
  endfunction : cmd_plan

  // ========================================================
  // Read register select
  function automatic logic [7:0] rd_byte(
    input logic [2:0] idx,
    input logic done,
    input logic [AUX_W-1:0] aux,
    input logic [RES_W-1:0] res
  );
    logic [7:0] b;
    b = 8'h00;
    // R17 status and result layout
    if (idx == IDX_STATUS) begin
      b[STAT_DONE] = done;
      b[STAT_AUX_LO +: AUX_W] = aux;
    end else if (idx == IDX_RES_FIRST) begin
      b = res[7:0];
    end else if (idx == IDX_RES_SECOND) begin
      b = res[15:8];
    end else if (idx == IDX_RES_THIRD) begin
      b = res[23:16];
    end
    return b;
  endfunction : rd_byte

  // ========================================================
  // Pin shifter and converter timer
  asc_shifter u_shifter (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .cs_b_i(cs_b_i),
    .sk_i(shift_clock_i),
    .si_i(serial_in_i),
    .bus(bus.port),
    .so_o(serial_out_o),
    .so_oe_o(serial_out_oe_o)
  );

  // R12 low byte is the first setup byte
  asc_integrator u_integrator (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .start_i(r.start),
    .abort_i(r.abort),
    .integ_i({cfg_r[IDX_CNT_HIGH], cfg_r[IDX_CNT_LOW]}),
    .mod_bit_i(mod_bit_i),
    .busy_o(conv_busy),
    .done_o(conv_done),
    .result_o(result)
  );

  assign aux_agree = ~(r.aux_s1 ^ r.aux_s2);
  assign plan = cmd_plan(bus.rx_byte[CODE_HI:CODE_LO]);

  // ========================================================
  // Sequencer
  always_comb begin
    n = r;
    cfg_nxt = cfg_r;
    n.start = 1'b0;
    n.abort = 1'b0;
    n.aux_s0 = aux_in_i;
    n.aux_s1 = r.aux_s0;
    n.aux_s2 = r.aux_s1;
    n.aux_q = (r.aux_s2 & aux_agree) | (r.aux_q & ~aux_agree);

    if (bus.rx_valid) begin
      if (bus.rx_byte == 8'h00) begin
        n.zeros = r.zeros + 3'h1;
      end else begin
        n.zeros = 3'h0;
      end

      // R11 four zero bytes resync
      if (bus.rx_byte == 8'h00 && r.zeros == ZERO_RUN - 3'h1) begin
        n.st = ST_CMD;
        n.tx_en = 1'b0;
        n.zeros = 3'h0;
      end else begin
        case (r.st)
          ST_CMD: begin
            // R06 command byte selects sequence
            if (plan.rd) begin
              n.st = ST_READ;
              n.idx = plan.idx;
              n.left = plan.cnt;
              n.tx_byte = rd_byte(plan.idx, r.done, r.aux_q, result);
              n.tx_en = 1'b1;
            end else if (plan.wr) begin
              n.st = ST_WRITE;
              n.idx = plan.idx;
              n.left = plan.cnt;
            end else if (bus.rx_byte[CODE_HI:CODE_LO] == CMD_START) begin
              // R23 done drops while converting
              n.start = 1'b1;
              n.done = 1'b0;
            end
            // R08 other codes leave all state
          end
          ST_READ: begin
            // R20 ascending, one frame each
            n.idx = r.idx + 3'h1;
            n.left = r.left - 2'h1;
            if (r.left == 2'h1) begin
              n.st = ST_CMD;
              n.tx_en = 1'b0;
            end else begin
              n.tx_byte = rd_byte(r.idx + 3'h1, r.done, r.aux_q, result);
            end
          end
          ST_WRITE: begin
            // R15 latched until overwritten
            cfg_nxt[r.idx] = bus.rx_byte;
            // R16 write aborts running conversion
            if (conv_busy || r.start) begin
              n.abort = 1'b1;
            end
            n.idx = r.idx + 3'h1;
            n.left = r.left - 2'h1;
            if (r.left == 2'h1) begin
              n.st = ST_CMD;
            end
          end
          default: begin
            n.st = ST_CMD;
            n.tx_en = 1'b0;
          end
        endcase
      end
    end

    // R18 fresh result marks completion
    if (conv_done) begin
      n.done = 1'b1;
    end
  end

  // ========================================================
  // Registers
  // R07 reset enters command mode
  // R24 reset clears conversion control
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      r <= '{st: ST_CMD, default: '0};
    end else begin
      r <= n;
    end
  end

  // R25 setup bytes ignore reset
  always_ff @(posedge clk_i) begin
    cfg_r <= cfg_nxt;
  end

  // ========================================================
  // Outputs
  assign bus.tx_byte = r.tx_byte;
  assign bus.tx_en = r.tx_en;
  // R02 pin mirrors status bit
  assign conversion_done_o = r.done;
  assign converting_o = conv_busy;
  // R13 attenuators and auxiliary outputs
  assign atten_en_o = cfg_r[IDX_ATTEN][ATTEN_LO +: AUX_W];
  assign aux_out_o = cfg_r[IDX_ATTEN][AUXO_LO +: AUX_W];
  // R14 mux, gain, junction, excitation
  assign mux_sel_o = cfg_r[IDX_MUX][MUX_LO +: 3];
  assign gain_sel_o = cfg_r[IDX_MUX][GAIN_LO +: 3];
  assign cjc_exc_o = cfg_r[IDX_MUX][CJC_BIT];
  assign exc_ctrl_o = cfg_r[IDX_EXC];
endmodule : asc_serial_port

/* File: dv/asc_host_model.sv */
/*
  Host serial master model: frames one byte per select cycle.
  Assumes pacing by the device clock; shift clock of 8 device clocks.
*/
module asc_host_model (
  input wire logic clk_i,
  input wire logic so_i,
  input wire logic so_oe_i,
  output logic cs_b_o,
  output logic sk_o,
  output logic si_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic so_w;
  // Released line reads inverted so a stale bit never passes
  assign so_w = so_oe_i ? so_i : !so_i;
  initial begin
    cs_b_o = 1'b1;
    sk_o = 1'b1;
    si_o = 1'b0;
  end
  // ==========================================================
  // Byte frame, n rising edges (8 for a legal frame)
  // framed byte, clock high
  task automatic xfer(input logic [7:0] d, input int n,
                      output logic [7:0] q);
    @(negedge clk_i) cs_b_o = 1'b0;
    repeat (6) @(negedge clk_i);
    for (int i = 7; i > 7 - n; i--) begin
      q[i] = so_w;
      sk_o = 1'b0;
      si_o = d[i];
      repeat (4) @(negedge clk_i);
      sk_o = 1'b1;
      repeat (4) @(negedge clk_i);
    end
    cs_b_o = 1'b1;
    si_o = !si_o;
    // Idle gap lets the next read byte load
    repeat (8) @(negedge clk_i);
  endtask : xfer
endmodule : asc_host_model

/* File: dv/asc_serial_port_monitor.sv */
/*
  Port checker of the serial command port.
  Assumes it is bound to the top module and sees only its ports.
*/
module asc_serial_port_monitor
  import asc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic cs_b_i,
  input wire logic shift_clock_i,
  input wire logic serial_out_o,
  input wire logic serial_out_oe_o,
  input wire logic conversion_done_o,
  input wire logic converting_o,
  input wire logic [AUX_W-1:0] atten_en_o,
  input wire logic [AUX_W-1:0] aux_out_o,
  input wire logic [2:0] mux_sel_o,
  input wire logic [7:0] exc_ctrl_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // ==========================================================
  // Serial output
  oe_idle_a: assert property (cs_b_i [*6] |-> !serial_out_oe_o)
    else $error("output driven with select high");
  oe_start_a: assert property ($rose(serial_out_oe_o)
    |-> $past(cs_b_i, 2) == 1'b0) else $error("output enabled early");
  oe_hold_a: assert property (serial_out_oe_o && !cs_b_i
    |=> serial_out_oe_o) else $error("output dropped mid frame");
  // Bit may only move within four clocks of a shift clock fall
  bit_edge_a: assert property (serial_out_oe_o && $past(serial_out_oe_o)
    && $changed(serial_out_o) |-> $past(shift_clock_i, 2) == 1'b0
    || $past(shift_clock_i, 3) == 1'b0 || $past(shift_clock_i, 4) == 1'b0)
    else $error("output bit moved off the fall");
  // ==========================================================
  // Conversion
  done_excl_a: assert property (converting_o |-> !conversion_done_o)
    else $error("done high while converting");
  // Done is registered one clock after the timer stops
  done_set_a: assert property ($rose(conversion_done_o)
    |-> $past(converting_o, 2)) else $error("done not at end");
  start_clr_a: assert property ($fell(conversion_done_o)
    |=> converting_o) else $error("start did not follow");
  // A normal end raises done one clock later; an abort leaves it low
  abort_cs_a: assert property ($fell(converting_o) ##1
    !conversion_done_o |-> $past(cs_b_i, 4))
    else $error("abort without a frame");
  // ==========================================================
  // Setup bytes change only after a completed frame
  setup_frame_a: assert property ($changed(atten_en_o)
    || $changed(mux_sel_o) |-> cs_b_i && $past(cs_b_i, 3))
    else $error("setup changed inside frame");
  out_frame_a: assert property ($changed(aux_out_o)
    || $changed(exc_ctrl_o) |-> $past(cs_b_i, 4))
    else $error("outputs changed inside frame");
  start_c: cover property ($rose(converting_o));
  abort_c: cover property ($fell(converting_o) ##1 !conversion_done_o);
  read_c: cover property ($rose(serial_out_oe_o));
endmodule : asc_serial_port_monitor

bind asc_serial_port asc_serial_port_monitor i_mon (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .cs_b_i(cs_b_i),
  .shift_clock_i(shift_clock_i), .serial_out_o(serial_out_o),
  .serial_out_oe_o(serial_out_oe_o),
  .conversion_done_o(conversion_done_o), .converting_o(converting_o),
  .atten_en_o(atten_en_o), .aux_out_o(aux_out_o),
  .mux_sel_o(mux_sel_o), .exc_ctrl_o(exc_ctrl_o)
);

/* File: dv/tb.sv */
/*
  Self-checking bench of the serial command port.
  Assumes the host model for pins and a bound port checker.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_b, cs_b, sk, si, so, so_oe, done, conv, mod_bit;
  logic cjc;
  logic [3:0] aux_in, aux_out, atten;
  logic [2:0] mux, gain;
  logic [7:0] exc;
  int error_cnt = 0;
  int checks = 0;
  int cyc;
  // ==========================================================
  // Clock, instances
  initial begin
    clk = 1'b0;
    forever #10 clk = !clk;
  end
  always @(posedge clk) if (conv === 1'b1) cyc <= cyc + 1;
  asc_host_model i_host (.clk_i(clk), .so_i(so), .so_oe_i(so_oe),
    .cs_b_o(cs_b), .sk_o(sk), .si_o(si));
  asc_serial_port i_dut (.clk_i(clk), .rst_b_i(rst_b), .cs_b_i(cs_b),
    .shift_clock_i(sk), .serial_in_i(si), .serial_out_o(so),
    .serial_out_oe_o(so_oe), .conversion_done_o(done),
    .converting_o(conv), .mod_bit_i(mod_bit), .aux_in_i(aux_in),
    .aux_out_o(aux_out), .atten_en_o(atten), .mux_sel_o(mux),
    .gain_sel_o(gain), .cjc_exc_o(cjc), .exc_ctrl_o(exc));
  // ==========================================================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tx(input logic [7:0] d);
    logic [7:0] q;
    i_host.xfer(d, 8, q);
  endtask : tx
  task automatic rx(input logic [7:0] exp);
    logic [7:0] q;
    i_host.xfer(8'h00, 8, q);
    chk(32'(q), 32'(exp));
  endtask : rx
  task automatic wait_done();
    for (int i = 0; i < 2000 && done !== 1'b1; i++) @(negedge clk);
    chk(32'(done), 32'h1);
  endtask : wait_done
  function automatic logic [31:0] setup();
    return {9'h0, atten, aux_out, mux, gain, cjc, exc};
  endfunction : setup
  task automatic end_of_test();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  // ==========================================================
  // Tests
  initial begin
    logic [7:0] q;
    rst_b = 1'b0;
    mod_bit = 1'b1;
    aux_in = 4'h9;
    cyc = 0;
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    chk(32'(so_oe), 32'h0);
    tx(8'he0); tx(8'ha5); tx(8'h5b); tx(8'hc3);
    chk(setup(), {9'h0, 4'h5, 4'ha, 3'h3, 3'h3, 1'b1, 8'hc3});
    tx(8'ha0); tx(8'h02); tx(8'h00);
    cyc = 0;
    tx(8'hf0);
    wait_done();
    chk(32'(cyc), 32'd64);
    tx(8'h50); rx(8'h20); rx(8'h00); rx(8'h00);
    tx(8'h10); rx(8'h89);
    chk(32'(done), 32'h1);
    // Single count writes, then a longer run low-going run
    tx(8'h80); tx(8'h10); tx(8'h90); tx(8'h00);
    mod_bit = 1'b0;
    cyc = 0;
    tx(8'hf0);
    tx(8'h10); rx(8'h09);
    tx(8'h20); rx(8'h20);
    wait_done();
    chk(32'(cyc), 32'd512);
    tx(8'h20); rx(8'h00);
    tx(8'h30); rx(8'hff);
    tx(8'h40); rx(8'hff);
    // Setup write mid conversion aborts but still latches
    tx(8'hf0);
    tx(8'hb0); tx(8'h3c);
    chk({30'h0, conv, done}, 32'h0);
    chk(setup(), {9'h0, 4'hc, 4'h3, 3'h3, 3'h3, 1'b1, 8'hc3});
    tx(8'h60); tx(8'h70); tx(8'h0f);
    i_host.xfer(8'hd0, 7, q);
    tx(8'h10); rx(8'h09);
    chk(setup(), {9'h0, 4'hc, 4'h3, 3'h3, 3'h3, 1'b1, 8'hc3});
    // Pending write takes the first of four zero bytes
    tx(8'h80); tx(8'h00); tx(8'h00); tx(8'h00); tx(8'h00);
    aux_in = 4'h6;
    tx(8'h10); rx(8'h06);
    // Reset during a conversion with a read pending
    tx(8'h80); tx(8'h10);
    tx(8'hf0);
    tx(8'h50);
    chk(32'(conv), 32'h1);
    rst_b = 1'b0;
    repeat (2) @(negedge clk);
    chk({30'h0, conv, done}, 32'h0);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    chk(setup(), {9'h0, 4'hc, 4'h3, 3'h3, 3'h3, 1'b1, 8'hc3});
    tx(8'h10); rx(8'h06);
    end_of_test();
  end
  initial begin
    #400000;
    error_cnt++;
    end_of_test();
  end
endmodule : tb
